// ===== core/timer16_defines.svh
// Register offsets, field codes, reset values and timing counts of the timer
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// Register byte addresses, one byte register per aligned word
`define OFS_COUNT_LO   8'h00
`define OFS_COUNT_HI   8'h04
`define OFS_CMPA_LO    8'h08
`define OFS_CMPA_HI    8'h0C
`define OFS_CMPB_LO    8'h10
`define OFS_CMPB_HI    8'h14
`define OFS_CAP_LO     8'h18
`define OFS_CAP_HI     8'h1C
`define OFS_CTRL_A     8'h20
`define OFS_CTRL_B     8'h24
`define OFS_FLAG       8'h28
`define OFS_MASK       8'h2C
`define OFS_POWER      8'h30

// Reset values and the control A write mask
`define POWER_RESET    1'b1
`define BYTE_RESET     8'h00
`define WORD_RESET     16'h0000
`define CTRL_A_WMASK   8'hF3

// Count range landmarks
`define COUNT_BOTTOM   16'h0000
`define COUNT_MAX      16'hFFFF
`define TOP_8BIT       16'h00FF
`define TOP_9BIT       16'h01FF
`define TOP_10BIT      16'h03FF

// Counting modes
`define MODE_NORMAL    4'h0
`define MODE_PWM8      4'h1
`define MODE_PWM9      4'h2
`define MODE_PWM10     4'h3
`define MODE_CTC_CMPA  4'h4
`define MODE_CTC_CAP   4'hC
`define MODE_PWM_CAP   4'hE
`define MODE_PWM_CMPA  4'hF

// Clock select codes and prescaler masks
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7
`define MASK_DIV8      10'h007
`define MASK_DIV64     10'h03F
`define MASK_DIV256    10'h0FF
`define MASK_DIV1024   10'h3FF
`define PRESC_STEP     10'h001

// Compare output actions
`define OM_OFF         2'h0
`define OM_TOGGLE      2'h1
`define OM_CLEAR       2'h2
`define OM_SET         2'h3

// Capture noise filter length in samples
`define FILTER_LEN     4

// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ===== core/timer16_pkg.sv
// Types shared by the timer files
package timer16_pkg;

  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] rsv;
    logic [1:0] mode_low;
  } control_a_t;

  typedef struct packed {
    logic       filter_en;
    logic       edge_rising;
    logic       source_comp;
    logic [1:0] mode_high;
    logic [2:0] clock_sel;
  } control_b_t;

  typedef struct packed {
    logic capture;
    logic match_b;
    logic match_a;
    logic overflow;
  } flags_t;

endpackage

// ===== core/capture_filter.sv
// Capture trigger synchroniser, noise filter and edge detector
`timescale 1ns/100ps
`default_nettype none
`include "timer16_defines.svh"
module capture_filter (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Trigger sources
  input  wire logic pin_in,
  input  wire logic comp_in,
  // Settings
  input  wire logic use_comp,
  input  wire logic filter_en,
  input  wire logic edge_rising,
  input  wire logic enable,
  // Result
  output logic      event_pulse
);

  logic                     sel_raw;
  logic                     sync1;
  logic                     sync2;
  logic [`FILTER_LEN-1:0]   hist;
  logic                     level;
  logic                     level_q;

  // Mux ahead of the synchroniser keeps one crossing for both sources
  assign sel_raw = use_comp ? comp_in : pin_in;

  // Two-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= sel_raw;
      sync2 <= sync1;
    end
  end

  // With filter_en set, level changes only after a run of equal samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist  <= '0;
      level <= 1'b0;
    end else begin
      hist <= {hist[`FILTER_LEN-2:0], sync2};
      if (!filter_en) begin
        level <= sync2;
      end else if (&hist) begin
        level <= 1'b1;
      end else if (~|hist) begin
        level <= 1'b0;
      end
    end
  end

  // Edge detection on the cleaned level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end

  assign event_pulse = enable && (edge_rising ? (level && !level_q) : (!level && level_q));

endmodule
`default_nettype wire

// ===== core/timer16_top.sv
// 16-bit timer/counter with byte-wide register access over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_top
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Timer pins
  input  wire logic        ext_count_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_in,
  output logic             compare_out_a,
  output logic             compare_out_a_en,
  output logic             compare_out_b,
  output logic             compare_out_b_en,
  // Status
  output logic [3:0]       int_req,
  output logic             at_bottom,
  output logic             at_max,
  output logic             at_top
);

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q;
  logic        wr_fire;
  logic        wr_en;
  logic        rd_fire;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_byte;
  logic [7:0]  temp;
  logic        temp_write;
  logic [15:0] count;
  logic [15:0] cmpa_buf;
  logic [15:0] cmpa_act;
  logic [15:0] cmpb_buf;
  logic [15:0] cmpb_act;
  logic [15:0] capture;
  control_a_t  ctrl_a;
  control_b_t  ctrl_b;
  flags_t      flags;
  flags_t      mask;
  logic        power_off;
  logic [3:0]  mode;
  logic        pwm;
  logic        top_is_cap;
  logic [15:0] top;
  logic [9:0]  presc;
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_s3;
  logic        raw_tick;
  logic        timer_tick;
  logic        cnt_write;
  logic        block_match;
  logic        wrap;
  logic        match_a;
  logic        match_b;
  logic        ovf;
  logic        cap_fire;
  logic [3:0]  clr;
  logic        a_en;
  logic        b_en;

  function automatic logic is_mapped(input logic [7:0] a);
    return a <= `OFS_POWER;
  endfunction

  function automatic logic is_high(input logic [7:0] a);
    return a == `OFS_COUNT_HI || a == `OFS_CMPA_HI || a == `OFS_CMPB_HI || a == `OFS_CAP_HI;
  endfunction

  // Next level of one compare output
  function automatic logic wave_next(input logic [1:0] om, input logic pw, input logic cur,
                                     input logic m, input logic w);
    logic n;
    n = cur;
    if (pw) begin
      if (m) n = (om == `OM_SET);
      if (w) n = (om == `OM_CLEAR);
      if (!om[1]) n = 1'b0;
    end else begin
      case (om)
        `OM_TOGGLE: if (m) n = ~cur;
        `OM_CLEAR:  if (m) n = 1'b0;
        `OM_SET:    if (m) n = 1'b1;
        default:    n = 1'b0;
      endcase
    end
    return n;
  endfunction

  // Write channel: address and data taken independently, then joined
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held;
  assign wr_en   = wr_fire && w_lane_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= `BYTE_RESET;
      w_data_q  <= `BYTE_RESET;
      w_lane_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata[7:0]; // Bytes ride in the low lane
        w_lane_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel, one outstanding read
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  assign rd_addr = {araddr[7:2], 2'b00};

  // High reads of counter and capture see the holding register
  always_comb begin
    case (rd_addr)
      `OFS_COUNT_LO: rd_byte = count[7:0];
      `OFS_COUNT_HI: rd_byte = temp;
      `OFS_CMPA_LO:  rd_byte = cmpa_buf[7:0];
      `OFS_CMPA_HI:  rd_byte = cmpa_buf[15:8];
      `OFS_CMPB_LO:  rd_byte = cmpb_buf[7:0];
      `OFS_CMPB_HI:  rd_byte = cmpb_buf[15:8];
      `OFS_CAP_LO:   rd_byte = capture[7:0];
      `OFS_CAP_HI:   rd_byte = temp;
      `OFS_CTRL_A:   rd_byte = ctrl_a;
      `OFS_CTRL_B:   rd_byte = ctrl_b;
      `OFS_FLAG:     rd_byte = {4'h0, flags};
      `OFS_MASK:     rd_byte = {4'h0, mask};
      `OFS_POWER:    rd_byte = {7'h00, power_off};
      default:       rd_byte = `BYTE_RESET;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= is_mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Shared holding register: high writes and counter or capture low reads update it
  assign temp_write = wr_en && is_high(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp <= `BYTE_RESET;
    end else if (temp_write) begin
      temp <= w_data_q;
    end else if (rd_fire && rd_addr == `OFS_COUNT_LO) begin
      temp <= count[15:8];
    end else if (rd_fire && rd_addr == `OFS_CAP_LO) begin
      temp <= capture[15:8];
    end
  end

  // Control, mask and power registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a    <= control_a_t'(`BYTE_RESET);
      ctrl_b    <= control_b_t'(`BYTE_RESET);
      mask      <= flags_t'(4'h0);
      power_off <= `POWER_RESET;
    end else if (wr_en) begin
      if (aw_addr_q == `OFS_CTRL_A) ctrl_a <= control_a_t'(w_data_q & `CTRL_A_WMASK);
      if (aw_addr_q == `OFS_CTRL_B) ctrl_b <= control_b_t'(w_data_q);
      if (aw_addr_q == `OFS_MASK) mask <= flags_t'(w_data_q[3:0]);
      if (aw_addr_q == `OFS_POWER) power_off <= w_data_q[0];
    end
  end

  // Mode decode and top selection
  assign mode       = {ctrl_b.mode_high, ctrl_a.mode_low};
  assign pwm        = mode inside {`MODE_PWM8, `MODE_PWM9, `MODE_PWM10,
                                   `MODE_PWM_CAP, `MODE_PWM_CMPA};
  assign top_is_cap = mode == `MODE_CTC_CAP || mode == `MODE_PWM_CAP;

  always_comb begin
    case (mode)
      `MODE_PWM8:     top = `TOP_8BIT;
      `MODE_PWM9:     top = `TOP_9BIT;
      `MODE_PWM10:    top = `TOP_10BIT;
      `MODE_CTC_CMPA: top = cmpa_act;
      `MODE_PWM_CMPA: top = cmpa_act;
      `MODE_CTC_CAP:  top = capture;
      `MODE_PWM_CAP:  top = capture;
      default:        top = `COUNT_MAX;
    endcase
  end

  // Prescaler runs only while powered; held cleared otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn || power_off) begin
      presc <= 10'h000;
    end else begin
      presc <= presc + `PRESC_STEP;
    end
  end

  // External count pin synchroniser and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Clock select picks source and edge
  always_comb begin
    unique case (ctrl_b.clock_sel)
      `CS_STOP:     raw_tick = 1'b0;
      `CS_DIV1:     raw_tick = 1'b1;
      `CS_DIV8:     raw_tick = (presc & `MASK_DIV8) == `MASK_DIV8;
      `CS_DIV64:    raw_tick = (presc & `MASK_DIV64) == `MASK_DIV64;
      `CS_DIV256:   raw_tick = (presc & `MASK_DIV256) == `MASK_DIV256;
      `CS_DIV1024:  raw_tick = (presc & `MASK_DIV1024) == `MASK_DIV1024;
      `CS_EXT_FALL: raw_tick = !ext_s2 && ext_s3;
      `CS_EXT_RISE: raw_tick = ext_s2 && !ext_s3;
    endcase
  end

  assign timer_tick = raw_tick && !power_off;
  assign cnt_write  = wr_en && aw_addr_q == `OFS_COUNT_LO;
  assign wrap       = timer_tick && count == top;

  // Counter: host write first, then wrap at top, else step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `WORD_RESET;
    end else if (cnt_write) begin
      count <= {temp, w_data_q};
    end else if (wrap) begin
      count <= `COUNT_BOTTOM;
    end else if (timer_tick) begin
      count <= count + 16'h0001;
    end
  end

  // A counter write hides the match on the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_match <= 1'b0;
    end else if (cnt_write) begin
      block_match <= 1'b1;
    end else if (timer_tick) begin
      block_match <= 1'b0;
    end
  end

  // Compare buffers; PWM modes only take new values at top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_buf <= `WORD_RESET;
      cmpb_buf <= `WORD_RESET;
      cmpa_act <= `WORD_RESET;
      cmpb_act <= `WORD_RESET;
    end else begin
      if (wr_en && aw_addr_q == `OFS_CMPA_LO) cmpa_buf <= {temp, w_data_q};
      if (wr_en && aw_addr_q == `OFS_CMPB_LO) cmpb_buf <= {temp, w_data_q};
      if (!pwm || wrap) begin
        cmpa_act <= cmpa_buf;
        cmpb_act <= cmpb_buf;
      end
    end
  end

  // Continuous compare against the active copies
  assign match_a = timer_tick && !block_match && count == cmpa_act;
  assign match_b = timer_tick && !block_match && count == cmpb_act;
  assign ovf     = pwm ? wrap : (timer_tick && count == `COUNT_MAX);

  // Capture trigger path
  capture_filter u_filter (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pin_in      (capture_input_pin),
    .comp_in     (comparator_in),
    .use_comp    (ctrl_b.source_comp),
    .filter_en   (ctrl_b.filter_en),
    .edge_rising (ctrl_b.edge_rising),
    .enable      (!power_off && !top_is_cap),
    .event_pulse (cap_fire)
  );

  // Capture register is host-writable only while it sets top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture <= `WORD_RESET;
    end else if (cap_fire) begin
      capture <= count;
    end else if (wr_en && top_is_cap && aw_addr_q == `OFS_CAP_LO) begin
      capture <= {temp, w_data_q};
    end
  end

  // Flags: write one clears, a same-cycle event wins
  assign clr = (wr_en && aw_addr_q == `OFS_FLAG) ? w_data_q[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= flags_t'(4'h0);
    end else begin
      flags <= flags_t'((flags & ~clr) | {cap_fire, match_b, match_a, ovf});
    end
  end

  assign int_req = flags & mask;

  // Waveform outputs; channel A silent when it sets the PWM top
  assign a_en = ctrl_a.out_mode_a != `OM_OFF && mode != `MODE_PWM_CMPA;
  assign b_en = ctrl_a.out_mode_b != `OM_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else begin
      compare_out_a <= a_en && wave_next(ctrl_a.out_mode_a, pwm, compare_out_a, match_a, wrap);
      compare_out_b <= wave_next(ctrl_a.out_mode_b, pwm, compare_out_b, match_b, wrap);
    end
  end

  assign compare_out_a_en = a_en;
  assign compare_out_b_en = b_en;

  // Landmark status
  assign at_bottom = count == `COUNT_BOTTOM;
  assign at_max    = count == `COUNT_MAX;
  assign at_top    = count == top;

  // Checks
  logic [15:0] wr_word;
  logic [7:0]  count_hi;
  logic [7:0]  cmpa_hi;
  assign wr_word  = {temp, w_data_q};
  assign count_hi = count[15:8];
  assign cmpa_hi  = cmpa_buf[15:8];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_power_gate: assert property (power_off |-> !timer_tick && !cap_fire)
    else $error("timer ticked while powered off");
  chk_low_write_load: assert property (cnt_write |=> count == $past(wr_word))
    else $error("counter not loaded with both bytes");
  chk_temp_on_read: assert property (rd_fire && rd_addr == `OFS_COUNT_LO && !temp_write
    |=> temp == $past(count_hi))
    else $error("holding register missed high byte");
  chk_cmp_read_direct: assert property (rd_fire && rd_addr == `OFS_CMPA_HI
    |=> rvalid && rdata[7:0] == $past(cmpa_hi))
    else $error("compare high read not direct");
  chk_stop_hold: assert property (ctrl_b.clock_sel == `CS_STOP && !cnt_write
    |=> $stable(count))
    else $error("counter moved without clock source");
  chk_match_flag: assert property (match_a |=> flags.match_a)
    else $error("match A flag not set");
  chk_capture_copy: assert property (cap_fire |=> flags.capture && capture == $past(count))
    else $error("capture copy and flag out of step");
  chk_top_wrap: assert property (wrap && !cnt_write |=> count == `COUNT_BOTTOM)
    else $error("counter did not wrap at top");
  chk_pwm_a_off: assert property (mode == `MODE_PWM_CMPA |-> !compare_out_a_en)
    else $error("output A driven while setting top");

  cov_match_a: cover property (match_a);
  cov_capture: cover property (cap_fire);
  cov_overflow: cover property (ovf ##1 flags.overflow);
  cov_write_resp: cover property (wr_fire ##1 bvalid);

endmodule
`default_nettype wire

// ===== test/host_model.sv
// Host bus model: byte-wide AXI4-Lite master standing in for the processor
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Handshakes judged at the falling edge so the rising edge is never raced
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic ta, tw, tb;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || (awready === 1'b1);
      tw = tw || (wready === 1'b1);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb) begin
      @(negedge aclk);
      tb   = (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] resp);
    logic ta, tr;
    ta = 1'b0;
    tr = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ta) begin
      @(negedge aclk);
      ta = (arready === 1'b1);
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (!tr) begin
      @(negedge aclk);
      tr   = (rvalid === 1'b1);
      d    = rdata[7:0];
      resp = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask
  // Wide access: high byte first on write, low first on read, never interleaved
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [1:0] r;
    wr(a + 8'h04, v[15:8], r);
    wr(a, v[7:0], r);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    logic [1:0] r;
    rd(a, v[7:0], r);
    rd(a + 8'h04, v[15:8], r);
  endtask
endmodule
`default_nettype wire

// ===== test/sixteen_bit_timer_byte_access_bench.sv
// Self-checking bench of the byte-access timer
`timescale 1ns/100ps
`default_nettype none
`include "timer16_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module sixteen_bit_timer_byte_access_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, ext_pin = 1'b0, cap_pin = 1'b0, comp_pin = 1'b0;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, oa, oae, ob, obe, bot, mx, tp;
  logic [3:0]  int_req;
  logic [15:0] v;
  int          bad_count = 0, n_checks = 0;
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  timer16_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ext_count_pin(ext_pin), .capture_input_pin(cap_pin),
    .comparator_in(comp_pin), .compare_out_a(oa), .compare_out_a_en(oae), .compare_out_b(ob),
    .compare_out_b_en(obe), .int_req(int_req), .at_bottom(bot), .at_max(mx), .at_top(tp));
  host_model i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic complete_run;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holding register untouched yet, power bit set, count at bottom
  task automatic reset_values;
    i_host.rd(`OFS_CAP_HI, d, r);
    `CHK(d, 8'h00)
    i_host.rd(`OFS_POWER, d, r);
    `CHK(d, 8'h01)
    `CHK(bot, 1'b1)
  endtask
  // Both bytes land together; no clock source keeps the count
  task automatic pair_access;
    i_host.wr(`OFS_POWER, 8'h00, r);
    i_host.wr16(`OFS_COUNT_LO, 16'h1234);
    repeat (20) @(posedge aclk);
    i_host.rd16(`OFS_COUNT_LO, v);
    `CHK(v, 16'h1234)
    `CHK(bot, 1'b0)
  endtask
  // One holding byte for all; compare high reads bypass it
  task automatic holding_shared;
    i_host.wr16(`OFS_CMPA_LO, 16'hABCD);
    i_host.rd(`OFS_COUNT_LO, d, r);
    i_host.rd(`OFS_CMPA_HI, d, r);
    `CHK(d, 8'hAB)
    i_host.rd(`OFS_COUNT_HI, d, r);
    `CHK(d, 8'h12)
  endtask
  // Control A reserved bits read zero; unmapped place refused
  task automatic direct_ctrl;
    i_host.wr(`OFS_CTRL_A, 8'hFF, r);
    i_host.rd(`OFS_CTRL_A, d, r);
    `CHK(d, `CTRL_A_WMASK)
    i_host.wr(`OFS_CTRL_A, 8'h00, r);
    i_host.wr(8'h40, 8'h55, r);
    `CHK(r, `RESP_SLVERR)
    i_host.rd(8'h40, d, r);
    `CHK({r, d}, {`RESP_SLVERR, 8'h00})
  endtask
  // Power gate, wrap past all ones, match A, masks and clearing
  task automatic count_flags;
    i_host.wr16(`OFS_CMPA_LO, 16'hFFF8);
    i_host.wr16(`OFS_CMPB_LO, 16'h8000);
    i_host.wr(`OFS_POWER, 8'h01, r);
    i_host.wr16(`OFS_COUNT_LO, 16'hFFF0);
    i_host.wr(`OFS_CTRL_B, {5'h0, `CS_DIV1}, r);
    repeat (10) @(posedge aclk);
    i_host.rd16(`OFS_COUNT_LO, v);
    `CHK(v, 16'hFFF0)
    i_host.wr(`OFS_POWER, 8'h00, r);
    repeat (40) @(posedge aclk);
    i_host.wr(`OFS_CTRL_B, {5'h0, `CS_STOP}, r);
    i_host.rd(`OFS_FLAG, d, r);
    `CHK(d, 8'h03)
    i_host.wr(`OFS_MASK, 8'h0F, r);
    `CHK(int_req, 4'h3)
    i_host.wr(`OFS_FLAG, 8'h0F, r);
    `CHK(int_req, 4'h0)
  endtask
  // One high-then-low pulse per step; long enough for the pin synchroniser
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge aclk) ext_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
  // External rising edges step the count, falling ones do not
  task automatic ext_clock;
    i_host.wr16(`OFS_COUNT_LO, 16'h0000);
    i_host.wr(`OFS_CTRL_B, {5'h0, `CS_EXT_RISE}, r);
    ext_pulses(3);
    i_host.rd16(`OFS_COUNT_LO, v);
    `CHK(v, 16'h0003)
    i_host.wr(`OFS_CTRL_B, {5'h0, `CS_STOP}, r);
  endtask
  // Filter swallows a spike; a clean edge stamps the count and flag
  task automatic capture;
    i_host.wr16(`OFS_COUNT_LO, 16'h0ABC);
    i_host.wr(`OFS_CTRL_B, 8'hC0, r);
    @(posedge aclk) cap_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    cap_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    i_host.rd(`OFS_FLAG, d, r);
    `CHK(d, 8'h00)
    i_host.wr(`OFS_CTRL_B, 8'h40, r);
    @(posedge aclk) cap_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    i_host.rd(`OFS_FLAG, d, r);
    `CHK(d, 8'h08)
    i_host.rd16(`OFS_CAP_LO, v);
    `CHK(v, 16'h0ABC)
    i_host.wr16(`OFS_COUNT_LO, 16'h0123);
    i_host.wr(`OFS_CTRL_B, 8'h60, r);
    @(posedge aclk) comp_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    i_host.rd16(`OFS_CAP_LO, v);
    `CHK(v, 16'h0123)
  endtask
  // Toggle on match, landmarks, PWM keeps the old compare until top
  task automatic wave_buffer;
    i_host.wr16(`OFS_CMPA_LO, 16'h0002);
    i_host.wr16(`OFS_CMPB_LO, 16'h0005);
    i_host.wr16(`OFS_COUNT_LO, 16'hFFFF);
    `CHK({mx, tp, oae, obe}, 4'hC)
    i_host.wr(`OFS_CTRL_A, 8'h40, r);
    i_host.wr(`OFS_CTRL_B, {5'h0, `CS_EXT_FALL}, r);
    i_host.wr16(`OFS_COUNT_LO, 16'h0000);
    i_host.wr(`OFS_FLAG, 8'h0F, r);
    ext_pulses(3);
    `CHK({oa, oae, obe}, 3'h6)
    i_host.rd(`OFS_FLAG, d, r);
    `CHK(d, 8'h02)
    i_host.wr(`OFS_CTRL_A, 8'h01, r);
    i_host.wr16(`OFS_CMPB_LO, 16'h0001);
    i_host.wr16(`OFS_COUNT_LO, 16'h0000);
    i_host.wr(`OFS_FLAG, 8'h0F, r);
    ext_pulses(3);
    i_host.rd(`OFS_FLAG, d, r);
    `CHK(d, 8'h02)
    i_host.wr16(`OFS_COUNT_LO, 16'h00FF);
    `CHK({mx, tp}, 2'h1)
    i_host.wr(`OFS_CTRL_B, 8'h18, r);
    i_host.wr(`OFS_CTRL_A, 8'hF3, r);
    `CHK({oae, obe}, 2'h1)
  endtask
  // Watchdog against a hung handshake
  initial begin
    #500us;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_values;
    pair_access;
    holding_shared;
    direct_ctrl;
    count_flags;
    ext_clock;
    capture;
    wave_buffer;
    complete_run;
  end
endmodule
`default_nettype wire
